/* rtl/dtc_timer_ctrl.sv */
// Dual timer/counter control and data registers on the special-function bus
//
// Contract
// (R1) Timer 1 gated: count needs pin and run
// (R2) Gate clear: run bit alone enables timer
// (R3) Timer 0 gated: count needs pin and run
// (R4) Timer 1 select: pin events or machine cycles
// (R5) Timer 0 select: pin events or machine cycles
// (R6) Mode 00: high byte, 5-bit low prescaler
// (R7) Mode 01: bytes cascaded, sixteen bits
// (R8) Mode 10: low byte reloads from high
// (R9) Timer 1 mode 11: counting stops
// (R10) Timer 0 mode 11: two separate bytes
// (R11) Timer 1 overflow sets flag, vector clears
// (R12) Timer 0 overflow sets flag, vector clears
// (R13) Timer 1 runs while its run bit set
// (R14) Timer 0 runs while its run bit set
// (R15) Interrupt 1 request on edge or level
// (R16) Interrupt 0 request on edge or level
// (R17) Vector clears edge requests; level follows pin
// (R18) Trigger bit set edge, clear level
// (R19) Low four bits never steer timers
// (R20) Each timer holds two byte registers
// (R21) Run/flag register resets zero, bit-writable
// (R22) Timer 0 bytes at 8C and 8A
// (R23) Timer ticks once per twelve clocks
// (R24) Counter samples pin once per machine cycle
// (R25) Mode register at 89, resets zero
// (R26) Hardware set beats vector clear
`timescale 1ns/10ps
`default_nettype none
`include "dtc_params.svh"

module dtc_timer_ctrl
    import dtc_pkg::*;
#(
    parameter int MC_CLKS = `DTC_MC_CLKS
)
(
    input  wire logic      i_clk_sys,
    input  wire logic      i_rstn,
    input  wire dtc_sfr_t  i_sfr,
    input  wire dtc_bit_t  i_bit,
    input  wire dtc_vec_t  i_vec,
    input  wire dtc_pins_t i_pins,
    output logic [7:0]     o_sfr_rdata,
    output logic           o_sfr_rvalid,
    output dtc_vec_t       o_req
);

    localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);

    // ------------------------------------------------------------------------
    // Registers and nets
    // ------------------------------------------------------------------------
    logic [7:0] runflag_r;
    logic [7:0] runflag_nxt;
    logic [7:0] mode_r;
    logic [7:0] lo_r [2];
    logic [7:0] hi_r [2];
    logic [3:0] pin_m_r;
    logic [3:0] pin_s_r;
    logic [1:0] gate_d_r;
    logic [1:0] samp_r;
    logic [3:0] mc_cnt_r;
    logic       mc_tick_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic [1:0] gate_s;
    logic [1:0] cin_s;
    logic [1:0] en;
    logic [1:0] tick;
    logic [1:0] step_en;
    logic [1:0] ovf_evt;
    logic [1:0] xfall;
    logic [1:0] run;
    dtc_mode_t  md [2];
    dtc_cnt_t   step [2];
    logic       split0;
    logic       split_hi_en;
    logic       wr_rf;

    assign gate_s = pin_s_r[3:2];
    assign cin_s  = pin_s_r[1:0];
    assign run    = {runflag_r[`DTC_B_RUN1], runflag_r[`DTC_B_RUN0]};
    assign wr_rf  = i_sfr.wr && (i_sfr.addr == `DTC_A_RUNFLAG);

    // ------------------------------------------------------------------------
    // Count step for one timer in its mode
    // ------------------------------------------------------------------------
    function automatic dtc_cnt_t cnt_step(input dtc_mode_t m, input logic is_t0,
                                          input logic [7:0] lo, input logic [7:0] hi);
        dtc_cnt_t r;
        r.lo  = lo;
        r.hi  = hi;
        r.ovf = 1'b0;
        unique case (m)
            DTC_M_PRESCALE:
            begin
                r.lo = {lo[7:5], 5'(lo[4:0] + 5'h01)}; // R6
                if (lo[4:0] == 5'h1F)
                begin
                    r.hi  = 8'(hi + 8'h01);
                    r.ovf = (hi == 8'hFF);
                end
            end
            DTC_M_CASCADE:
            begin
                {r.hi, r.lo} = 16'({hi, lo} + 16'h0001); // R7
                r.ovf        = ({hi, lo} == 16'hFFFF);
            end
            DTC_M_RELOAD:
            begin
                r.lo  = (lo == 8'hFF) ? hi : 8'(lo + 8'h01); // R8
                r.ovf = (lo == 8'hFF);
            end
            DTC_M_SPLIT:
            begin
                if (is_t0)
                begin
                    r.lo  = 8'(lo + 8'h01); // R10
                    r.ovf = (lo == 8'hFF);
                end
            end
        endcase
        return r;
    endfunction : cnt_step

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_m_r  <= 4'hF;
            pin_s_r  <= 4'hF;
            gate_d_r <= 2'h3;
        end
        else
        begin
            pin_m_r  <= i_pins;
            pin_s_r  <= pin_m_r;
            gate_d_r <= gate_s;
        end
    end

    assign xfall = gate_d_r & ~gate_s;

    // ------------------------------------------------------------------------
    // Machine-cycle divider
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mc_cnt_r  <= 4'h0;
            mc_tick_r <= 1'b0;
        end
        else
        begin
            mc_tick_r <= (mc_cnt_r == MC_LAST); // R23
            mc_cnt_r  <= (mc_cnt_r == MC_LAST) ? 4'h0 : 4'(mc_cnt_r + 4'h1);
        end
    end

    // ------------------------------------------------------------------------
    // Counter-input sampling, one sample per machine cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            samp_r <= 2'h0;
        end
        else if (mc_tick_r)
        begin
            samp_r <= cin_s; // R24
        end
    end

    // ------------------------------------------------------------------------
    // Enables and steps per timer
    // ------------------------------------------------------------------------
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_tmr
            localparam int MB = (g == 0) ? `DTC_B_MODE0 : `DTC_B_MODE1;
            localparam int GB = (g == 0) ? `DTC_B_GATE0 : `DTC_B_GATE1;
            localparam int CB = (g == 0) ? `DTC_B_CSEL0 : `DTC_B_CSEL1;
            assign md[g]      = dtc_mode_t'(mode_r[MB+1:MB]);
            assign en[g]      = run[g] && (!mode_r[GB] || gate_s[g]); // R1 R2 R3 R13 R14
            assign tick[g]    = mode_r[CB] ? (mc_tick_r && samp_r[g] && !cin_s[g]) : mc_tick_r; // R4 R5 R24
            assign step_en[g] = en[g] && tick[g];
            assign step[g]    = cnt_step(md[g], (g == 0), lo_r[g], hi_r[g]);
        end
    endgenerate

    assign split0      = (md[0] == DTC_M_SPLIT);
    assign split_hi_en = split0 && run[1] && mc_tick_r; // R10
    assign ovf_evt[0]  = step_en[0] && step[0].ovf;
    assign ovf_evt[1]  = split0 ? (split_hi_en && (hi_r[0] == 8'hFF))
                                : (step_en[1] && step[1].ovf && (md[1] != DTC_M_SPLIT)); // R9 R10

    // ------------------------------------------------------------------------
    // Data registers, two bytes per timer
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                lo_r[i] <= `DTC_RST_COUNT;
                hi_r[i] <= `DTC_RST_COUNT;
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++) // R20
            begin
                if (i_sfr.wr && (i_sfr.addr == ((i == 0) ? `DTC_A_T0LO : `DTC_A_T1LO))) // R22
                begin
                    lo_r[i] <= i_sfr.wdata;
                end
                else if (step_en[i])
                begin
                    lo_r[i] <= step[i].lo;
                end
                if (i_sfr.wr && (i_sfr.addr == ((i == 0) ? `DTC_A_T0HI : `DTC_A_T1HI))) // R22
                begin
                    hi_r[i] <= i_sfr.wdata;
                end
                else if ((i == 0) && split0)
                begin
                    if (split_hi_en)
                    begin
                        hi_r[i] <= 8'(hi_r[i] + 8'h01); // R10
                    end
                end
                else if (step_en[i])
                begin
                    hi_r[i] <= step[i].hi;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mode_r <= `DTC_RST_MODE; // R25
        end
        else if (i_sfr.wr && (i_sfr.addr == `DTC_A_MODE))
        begin
            mode_r <= i_sfr.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Run/flag register next value
    // ------------------------------------------------------------------------
    always_comb
    begin
        runflag_nxt = runflag_r;
        if (wr_rf)
        begin
            runflag_nxt = i_sfr.wdata;
        end
        if (i_bit.wr)
        begin
            runflag_nxt[i_bit.sel] = i_bit.val; // R21
        end
        if (i_vec.timer1)
        begin
            runflag_nxt[`DTC_B_OVF1] = 1'b0; // R11
        end
        if (i_vec.timer0)
        begin
            runflag_nxt[`DTC_B_OVF0] = 1'b0; // R12
        end
        if (ovf_evt[1])
        begin
            runflag_nxt[`DTC_B_OVF1] = 1'b1; // R11 R26
        end
        if (ovf_evt[0])
        begin
            runflag_nxt[`DTC_B_OVF0] = 1'b1; // R12 R26
        end
        for (int k = 0; k < 2; k++)
        begin
            if (runflag_r[`DTC_B_XTYP0 + 2 * k]) // R18 R19
            begin
                if (i_vec[2 * k + 1])
                begin
                    runflag_nxt[`DTC_B_XREQ0 + 2 * k] = 1'b0; // R17
                end
                if (xfall[k])
                begin
                    runflag_nxt[`DTC_B_XREQ0 + 2 * k] = 1'b1; // R15 R16
                end
            end
            else
            begin
                runflag_nxt[`DTC_B_XREQ0 + 2 * k] = !gate_s[k]; // R15 R16 R17
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            runflag_r <= `DTC_RST_RUNFLAG; // R21
        end
        else
        begin
            runflag_r <= runflag_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= i_sfr.rd;
            if (i_sfr.rd)
            begin
                unique case (i_sfr.addr)
                    `DTC_A_RUNFLAG: rdata_r <= runflag_r;
                    `DTC_A_MODE:    rdata_r <= mode_r;
                    `DTC_A_T0LO:    rdata_r <= lo_r[0];
                    `DTC_A_T1LO:    rdata_r <= lo_r[1];
                    `DTC_A_T0HI:    rdata_r <= hi_r[0];
                    `DTC_A_T1HI:    rdata_r <= hi_r[1];
                    default:        rdata_r <= 8'h00;
                endcase
            end
        end
    end

    assign o_sfr_rdata  = rdata_r;
    assign o_sfr_rvalid = rvalid_r;
    assign o_req        = '{ext_irq1: runflag_r[`DTC_B_XREQ1], timer1: runflag_r[`DTC_B_OVF1],
                            ext_irq0: runflag_r[`DTC_B_XREQ0], timer0: runflag_r[`DTC_B_OVF0]};

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    a_gate_t0_block: assert property (mode_r[`DTC_B_GATE0] && !gate_s[0] |-> !en[0]) // R3
        else $error("timer 0 enabled with gate pin low");
    a_gate_t1_block: assert property (mode_r[`DTC_B_GATE1] && !gate_s[1] |-> !en[1]) // R1
        else $error("timer 1 enabled with gate pin low");
    a_ungated_run: assert property (!mode_r[`DTC_B_GATE0] && run[0] |-> en[0]) // R2
        else $error("ungated timer 0 not enabled");
    a_mc_spacing: assert property (mc_tick_r |=> !mc_tick_r [*8] ##4 mc_tick_r) // R23
        else $error("machine cycle not twelve clocks");
    a_t1_stop_hold: assert property ((md[1] == DTC_M_SPLIT) && !i_sfr.wr // R9
                                     |=> $stable(lo_r[1]) && $stable(hi_r[1]))
        else $error("timer 1 counted in mode 11");
    a_ovf1_sets: assert property (ovf_evt[1] |=> runflag_r[`DTC_B_OVF1]) // R11
        else $error("timer 1 overflow flag not set");
    a_ovf0_sets: assert property (ovf_evt[0] && i_vec.timer0 |=> runflag_r[`DTC_B_OVF0]) // R12
        else $error("timer 0 overflow lost to vector clear");
    a_level_follow: assert property (!runflag_r[`DTC_B_XTYP0] |=> runflag_r[`DTC_B_XREQ0] == !$past(gate_s[0])) // R17
        else $error("level request does not follow pin");
    a_edge_req1: assert property (runflag_r[`DTC_B_XTYP1] && xfall[1] |=> runflag_r[`DTC_B_XREQ1]) // R15
        else $error("edge request 1 not set");
    a_reload_low: assert property ((md[0] == DTC_M_RELOAD) && step_en[0] && (lo_r[0] == 8'hFF) && !i_sfr.wr
                                   |=> lo_r[0] == $past(hi_r[0])) // R8
        else $error("low byte not reloaded");

endmodule : dtc_timer_ctrl
`default_nettype wire

/* rtl/dtc_params.svh */
// Register offsets, field positions, reset values and timing counts of the dual timer
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define DTC_A_RUNFLAG 8'h88
`define DTC_A_MODE    8'h89
`define DTC_A_T0LO    8'h8A
`define DTC_A_T1LO    8'h8B
`define DTC_A_T0HI    8'h8C
`define DTC_A_T1HI    8'h8D

// ----------------------------------------------------------------------------
// Run/flag register bits
// ----------------------------------------------------------------------------
`define DTC_B_OVF1  7
`define DTC_B_RUN1  6
`define DTC_B_OVF0  5
`define DTC_B_RUN0  4
`define DTC_B_XREQ1 3
`define DTC_B_XTYP1 2
`define DTC_B_XREQ0 1
`define DTC_B_XTYP0 0

// ----------------------------------------------------------------------------
// Mode register bits, timer 1 in the upper nibble
// ----------------------------------------------------------------------------
`define DTC_B_GATE1 7
`define DTC_B_CSEL1 6
`define DTC_B_MODE1 4
`define DTC_B_GATE0 3
`define DTC_B_CSEL0 2
`define DTC_B_MODE0 0

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define DTC_RST_RUNFLAG 8'h00
`define DTC_RST_MODE    8'h00
`define DTC_RST_COUNT   8'h00
`define DTC_MC_CLKS     12

`endif

/* rtl/dtc_pkg.sv */
// Types shared by the dual timer/counter control block
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_M_PRESCALE = 2'b00,
        DTC_M_CASCADE  = 2'b01,
        DTC_M_RELOAD   = 2'b10,
        DTC_M_SPLIT    = 2'b11
    } dtc_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dtc_sfr_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] sel;
        logic       val;
    } dtc_bit_t;

    typedef struct packed {
        logic ext_irq1;
        logic timer1;
        logic ext_irq0;
        logic timer0;
    } dtc_vec_t;

    typedef struct packed {
        logic [1:0] gate_pin;
        logic [1:0] count_input;
    } dtc_pins_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic       ovf;
    } dtc_cnt_t;

endpackage : dtc_pkg

/* tb/dtc_pin_model.sv */
// Pin-side model: gate/interrupt pins and count inputs
`timescale 1ns/10ps
`default_nettype none
`include "dtc_params.svh"

module dtc_pin_model
    import dtc_pkg::*;
(
    input  wire logic    i_clk_sys,
    output var dtc_pins_t o_pins
);
    // ------------------------------------------------------------------------
    // Pins idle high through pull-ups
    // ------------------------------------------------------------------------
    initial
    begin
        o_pins = '1;
    end

    task automatic set_gate(input int t, input logic v);
        @(negedge i_clk_sys);
        o_pins.gate_pin[t] = v;
    endtask : set_gate

    // Falling edges, each level held two machine cycles
    task automatic pulse(input int t, input int n);
        repeat (n)
        begin
            @(negedge i_clk_sys);
            o_pins.count_input[t] = 1'b0;
            repeat (2 * `DTC_MC_CLKS) @(negedge i_clk_sys);
            o_pins.count_input[t] = 1'b1;
            repeat (2 * `DTC_MC_CLKS) @(negedge i_clk_sys);
        end
    endtask : pulse
endmodule : dtc_pin_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench of the dual timer/counter control block
`timescale 1ns/10ps
`default_nettype none
`include "dtc_params.svh"

module tb
    import dtc_pkg::*;
;
    logic       i_clk_sys;
    logic       i_rstn;
    dtc_sfr_t   sfr;
    dtc_bit_t   bitw;
    dtc_vec_t   vec;
    dtc_pins_t  pins;
    logic [7:0] rdata;
    logic       rvalid;
    dtc_vec_t   req;
    int         fails;
    int         compares;
    int         n;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] ra [7];

    always #10 i_clk_sys = ~i_clk_sys;

    dtc_timer_ctrl #(.MC_CLKS(`DTC_MC_CLKS)) i_dut (
        .i_clk_sys    (i_clk_sys),
        .i_rstn       (i_rstn),
        .i_sfr        (sfr),
        .i_bit        (bitw),
        .i_vec        (vec),
        .i_pins       (pins),
        .o_sfr_rdata  (rdata),
        .o_sfr_rvalid (rvalid),
        .o_req        (req)
    );

    dtc_pin_model i_pin (
        .i_clk_sys (i_clk_sys),
        .o_pins    (pins)
    );

    // ------------------------------------------------------------------------
    // Report and compare
    // ------------------------------------------------------------------------
    task automatic complete_run();
        $display("Counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Value must have moved away from the old one
    task automatic cmp_moved(input logic [7:0] got, input logic [7:0] old);
        compares++;
        if (got === old || $isunknown(got))
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=not %h", $time, got, old);
        end
    endtask : cmp_moved

    task automatic endt(input string s);
        $display("Test %s done", s);
    endtask : endt

    // ------------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clk_sys);
        sfr = '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge i_clk_sys);
        sfr = '0;
        cmp({7'h00, rvalid}, 8'h01);
        d = rdata;
    endtask : rd

    task automatic bw(input int s, input logic b);
        @(negedge i_clk_sys);
        bitw = '{wr: 1'b1, sel: 3'(s), val: b};
        @(negedge i_clk_sys);
        bitw = '0;
    endtask : bw

    task automatic vp(input int b);
        @(negedge i_clk_sys);
        vec = dtc_vec_t'(4'b0001 << b);
        @(negedge i_clk_sys);
        vec = '0;
    endtask : vp

    task automatic wait_req(input int b, input logic e, input int lim, output int k);
        k = 0;
        while (req[b] !== e)
        begin
            @(negedge i_clk_sys);
            k++;
            if (k > lim)
            begin
                fails++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, req[b], e);
                complete_run();
            end
        end
    endtask : wait_req

    // Run timer 0 to overflow, then check both bytes
    task automatic ovf(input logic [7:0] md, hi, lo, ehi, elo, msk);
        wr(`DTC_A_T0HI, hi);
        wr(`DTC_A_T0LO, lo);
        wr(`DTC_A_MODE, md);
        bw(`DTC_B_RUN0, 1'b1);
        wait_req(0, 1'b1, 40, n);
        bw(`DTC_B_RUN0, 1'b0);
        rd(`DTC_A_T0HI, v);
        cmp(v, ehi);
        rd(`DTC_A_T0LO, v);
        cmp(v & msk, elo);
        vp(0);
        cmp({7'h00, req.timer0}, 8'h00);
    endtask : ovf

    // ------------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------------
    initial
    begin
        i_clk_sys = 1'b0;
        i_rstn = 1'b0;
        sfr = '0;
        bitw = '0;
        vec = '0;
        fails = 0;
        compares = 0;
        ra = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E};
        repeat (8) @(negedge i_clk_sys);
        i_rstn = 1'b1;

        foreach (ra[i])
        begin
            rd(ra[i], v);
            cmp(v, 8'h00);
        end
        for (int i = 1; i < 7; i++)
        begin
            wr(ra[i], ra[i] ^ 8'hC3);
            rd(ra[i], v);
            cmp(v, (i == 6) ? 8'h00 : ra[i] ^ 8'hC3);
        end
        endt("map");

        for (int t = 0; t < 2; t++)
        begin
            wr(8'(`DTC_A_T0LO + t), 8'h00);
            wr(`DTC_A_MODE, 8'(8'h09 << (4 * t)));
            i_pin.set_gate(t, 1'b0);
            bw(4 + 2 * t, 1'b1);
            wait_req(2 * t + 1, 1'b1, 8, n);
            rd(`DTC_A_RUNFLAG, v);
            cmp(v, 8'(8'h12 << (2 * t)));
            repeat (40) @(negedge i_clk_sys);
            rd(8'(`DTC_A_T0LO + t), v);
            cmp(v, 8'h00);
            i_pin.set_gate(t, 1'b1);
            repeat (40) @(negedge i_clk_sys);
            rd(8'(`DTC_A_T0LO + t), v);
            cmp_moved(v, 8'h00);
            bw(4 + 2 * t, 1'b0);
            rd(8'(`DTC_A_T0LO + t), v);
            repeat (40) @(negedge i_clk_sys);
            rd(8'(`DTC_A_T0LO + t), w);
            cmp(w, v);
            wr(`DTC_A_MODE, 8'(8'h01 << (4 * t)));
            i_pin.set_gate(t, 1'b0);
            bw(4 + 2 * t, 1'b1);
            repeat (40) @(negedge i_clk_sys);
            rd(8'(`DTC_A_T0LO + t), w);
            cmp_moved(w, v);
            bw(4 + 2 * t, 1'b0);
            i_pin.set_gate(t, 1'b1);
        end
        endt("gate");

        ovf(8'h00, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h1F);
        ovf(8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF);
        ovf(8'h02, 8'hA5, 8'hFF, 8'hA5, 8'hA5, 8'hFF);
        endt("modes");

        wr(`DTC_A_T0HI, 8'hFF);
        wr(`DTC_A_T0LO, 8'hFF);
        wr(`DTC_A_MODE, 8'h02);
        bw(`DTC_B_RUN0, 1'b1);
        wait_req(0, 1'b1, 40, n);
        vp(0);
        wait_req(0, 1'b1, 20, n);
        cmp(8'(n), 8'h0A);
        repeat (10) @(negedge i_clk_sys);
        vp(0);
        cmp({7'h00, req.timer0}, 8'h01);
        bw(`DTC_B_RUN0, 1'b0);
        vp(0);
        cmp({7'h00, req.timer0}, 8'h00);
        endt("tick");

        for (int t = 0; t < 2; t++)
        begin
            wr(8'(`DTC_A_T0LO + t), 8'h00);
            wr(`DTC_A_MODE, 8'(8'h05 << (4 * t)));
            bw(4 + 2 * t, 1'b1);
            repeat (40) @(negedge i_clk_sys);
            rd(8'(`DTC_A_T0LO + t), v);
            cmp(v, 8'h00);
            i_pin.pulse(t, 3);
            rd(8'(`DTC_A_T0LO + t), v);
            cmp(v, 8'h03);
            bw(4 + 2 * t, 1'b0);
        end
        endt("counter");

        wr(`DTC_A_T1HI, 8'hFF);
        wr(`DTC_A_T1LO, 8'hFF);
        wr(`DTC_A_MODE, 8'h10);
        bw(`DTC_B_RUN1, 1'b1);
        wait_req(2, 1'b1, 40, n);
        vp(2);
        cmp({7'h00, req.timer1}, 8'h00);
        wr(`DTC_A_T0HI, 8'hFF);
        wr(`DTC_A_T0LO, 8'h00);
        wr(`DTC_A_MODE, 8'h03);
        wait_req(2, 1'b1, 40, n);
        rd(`DTC_A_T0LO, v);
        cmp(v, 8'h00);
        cmp({7'h00, req.timer0}, 8'h00);
        vp(2);
        wr(`DTC_A_T1LO, 8'h05);
        wr(`DTC_A_MODE, 8'h30);
        repeat (40) @(negedge i_clk_sys);
        rd(`DTC_A_T1LO, v);
        cmp(v, 8'h05);
        bw(`DTC_B_RUN1, 1'b0);
        endt("split");

        for (int t = 0; t < 2; t++)
        begin
            i_pin.set_gate(t, 1'b0);
            wait_req(2 * t + 1, 1'b1, 8, n);
            vp(2 * t + 1);
            cmp({7'h00, req[2 * t + 1]}, 8'h01);
            i_pin.set_gate(t, 1'b1);
            wait_req(2 * t + 1, 1'b0, 8, n);
            bw(2 * t, 1'b1);
            i_pin.set_gate(t, 1'b0);
            wait_req(2 * t + 1, 1'b1, 8, n);
            i_pin.set_gate(t, 1'b1);
            repeat (8) @(negedge i_clk_sys);
            cmp({7'h00, req[2 * t + 1]}, 8'h01);
            vp(2 * t + 1);
            cmp({7'h00, req[2 * t + 1]}, 8'h00);
            bw(2 * t, 1'b0);
        end
        endt("irq");
        complete_run();
    end
endmodule : tb
`default_nettype wire
